// ==== fpec_pkg.sv ====
// Constants and types shared by the flash program and erase control block
package fpec_pkg;

  // ==========================================================
  // Address map
  localparam logic [15:0] FPEC_CTRL_ADDR = 16'hFE08;
  localparam logic [11:0] FPEC_REG_PAGE  = 12'hFE0;
  localparam logic [15:0] FPEC_PROT_ADDR = 16'hFFBE;
  localparam logic [15:0] FPEC_TRIM_ADDR = 16'hFFC0;
  localparam logic [1:0]  FPEC_ARR_TOP   = 2'h3;
  localparam int          FPEC_ARR_AW    = 14;
  localparam int          FPEC_ARR_BYTES = 16384;

  // ==========================================================
  // Erase page and program row geometry
  localparam int          FPEC_PAGE_SH   = 6;
  localparam int          FPEC_ROW_SH    = 5;
  localparam logic [5:0]  FPEC_PAGE_LAST = 6'h3F;
  localparam logic [13:0] FPEC_ARR_LAST  = 14'h3FFF;
  localparam logic [5:0]  FPEC_PROT_LOW  = 6'h00;

  // ==========================================================
  // Data values
  localparam logic [7:0]  FPEC_ERASED    = 8'hFF;
  localparam logic [7:0]  FPEC_BPR_OPEN  = 8'hFF;
  localparam logic [7:0]  FPEC_RD_NONE   = 8'h00;
  localparam logic [3:0]  FPEC_CTRL_PAD  = 4'h0;

  // ==========================================================
  // Control register, bits 3..0: high voltage, whole array, erase, program
  typedef struct packed {
    logic high_voltage_enable;
    logic whole_array_select;
    logic erase;
    logic program_select;
  } fpec_ctrl_t;

  typedef struct packed {
    fpec_ctrl_t  ctl;
    logic        armed;
    logic        prot_read;
    logic [15:0] lat_addr;
    logic        sweep_on;
    logic        sweep_done;
    logic [13:0] sweep_idx;
    logic [7:0]  rdata;
  } fpec_state_t;

  localparam fpec_state_t FPEC_STATE_RESET = '0;

endpackage

// ==== fpec_top.sv ====
// Flash program and erase sequencer with its embedded array
`timescale 1ns/1ps
// Contract
// RQ1 - Smallest erasable region is 64 bytes
// RQ2 - One program cycle writes one 32-byte row
// RQ3 - Erased bits read one, programmed bits zero
// RQ4 - High voltage set only after proper sequence
// RQ5 - High voltage bit drives pump on/off
// RQ6 - Whole array bit selects mass erase
// RQ7 - Erase bit selects erase configuration
// RQ8 - Program bit selects program configuration
// RQ9 - Erase and program never both one
// RQ10 - Page is 64 aligned bytes, vectors included
// RQ11 - Any single page erasable alone
// RQ12 - Software follows page erase step order
// RQ13 - Software follows mass erase step order
// RQ14 - Mass erase refused unless protect byte FF; code tests whole array and erase as set before the high voltage write
// RQ15 - Sequences run from code outside array
// RQ16 - Steps in order, unrelated work allowed
// RQ17 - Vector page or mass erase clears trim
// RQ18 - Secured monitor dummy write hits protect byte
// RQ19 - Dummy write latches target page or row
// RQ20 - High voltage blocked for protected target
// RQ21 - Software follows row program step order
// RQ22 - Protect bits form start address bits 13:6
module fpec_top
  import fpec_pkg::*;
(
  // Clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        RESET_N,
  // Register and array port
  input  wire logic [15:0] ADDR,
  input  wire logic [7:0]  WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic      [7:0]  RDATA,
  // Array status
  output logic             PUMP_ON,
  output logic             SWEEP_BUSY
);

  // ==========================================================
  // Storage
  logic [7:0]  mem [FPEC_ARR_BYTES];
  fpec_state_t s;
  fpec_state_t next_s;

  logic [13:0] idx;
  logic        is_ctrl;
  logic        in_arr;
  logic [7:0]  bpr;
  logic [15:0] prot_start;
  logic        target_prot;
  logic        hv_ok;
  logic        prog_wr;
  logic        row_hit;
  fpec_ctrl_t  wctl;

  assign idx        = ADDR[FPEC_ARR_AW-1:0];
  assign is_ctrl    = (ADDR == FPEC_CTRL_ADDR);
  assign in_arr     = (ADDR[15:14] == FPEC_ARR_TOP)
                      && (ADDR[15:4] != FPEC_REG_PAGE);
  assign bpr        = mem[FPEC_PROT_ADDR[FPEC_ARR_AW-1:0]];
  assign prot_start = {FPEC_ARR_TOP, bpr, FPEC_PROT_LOW}; // RQ22
  assign target_prot = (bpr != FPEC_BPR_OPEN)
                       && (s.lat_addr >= prot_start); // RQ20
  assign wctl       = fpec_ctrl_t'(WDATA[3:0]);
  assign row_hit    = (idx[13:FPEC_ROW_SH]
                       == s.lat_addr[13:FPEC_ROW_SH]);
  // Mass erase needs an open protect byte only if whole array and erase were set by an
  // earlier control write; any erase or program needs the target outside the protected range
  assign hv_ok = (s.ctl.erase ^ s.ctl.program_select) // RQ4
                 && s.armed && s.prot_read && !target_prot // RQ20
                 && !(s.ctl.erase && s.ctl.whole_array_select
                      && bpr != FPEC_BPR_OPEN); // RQ14
  assign prog_wr = WR && in_arr && s.ctl.program_select
                   && s.ctl.high_voltage_enable && s.armed
                   && row_hit; // RQ2

  // ==========================================================
  // Next state
  always_comb
  begin
    next_s       = s;
    next_s.rdata = FPEC_RD_NONE;
    if (RD)
    begin
      if (is_ctrl)
        next_s.rdata = {FPEC_CTRL_PAD, s.ctl};
      else if (in_arr)
        next_s.rdata = mem[idx]; // RQ3
    end
    if (RD && ADDR == FPEC_PROT_ADDR
        && (s.ctl.erase || s.ctl.program_select))
      next_s.prot_read = 1'b1;
    if (WR && is_ctrl)
    begin
      next_s.ctl.whole_array_select = wctl.whole_array_select; // RQ6
      // Writing both selects at once is ignored for both bits
      if (!(wctl.erase && wctl.program_select)) // RQ9
      begin
        next_s.ctl.erase          = wctl.erase; // RQ7
        next_s.ctl.program_select = wctl.program_select; // RQ8
      end
      if (!wctl.high_voltage_enable)
        next_s.ctl.high_voltage_enable = 1'b0; // RQ5
      else if (hv_ok)
        next_s.ctl.high_voltage_enable = 1'b1; // RQ4
    end
    // Dummy write captures the target; later writes do not move it
    if (WR && in_arr && (s.ctl.erase || s.ctl.program_select)
        && !s.ctl.high_voltage_enable && !s.armed)
    begin
      next_s.armed    = 1'b1; // RQ19
      next_s.lat_addr = ADDR;
    end
    if (!next_s.ctl.erase && !next_s.ctl.program_select
        && !next_s.ctl.high_voltage_enable)
    begin
      next_s.armed     = 1'b0;
      next_s.prot_read = 1'b0;
    end
    // Erase sweep: one byte per clock, once per high voltage phase
    if (s.sweep_on)
    begin
      next_s.sweep_idx = s.sweep_idx + 14'h0001;
      if ((s.ctl.whole_array_select && s.sweep_idx == FPEC_ARR_LAST)
          || (!s.ctl.whole_array_select
              && s.sweep_idx[FPEC_PAGE_SH-1:0] == FPEC_PAGE_LAST)) // RQ1
      begin
        next_s.sweep_on   = 1'b0;
        next_s.sweep_done = 1'b1;
      end
      if (!s.ctl.high_voltage_enable || !s.ctl.erase)
        next_s.sweep_on = 1'b0;
    end
    else if (s.ctl.high_voltage_enable && s.ctl.erase
             && !s.sweep_done)
    begin
      next_s.sweep_on  = 1'b1;
      // Page sweep covers the vector page, trim byte included
      next_s.sweep_idx = s.ctl.whole_array_select ? '0
          : {s.lat_addr[13:FPEC_PAGE_SH], FPEC_PROT_LOW}; // RQ10 RQ17
    end
    if (!s.ctl.high_voltage_enable)
      next_s.sweep_done = 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      s <= FPEC_STATE_RESET;
    else
      s <= next_s;
  end

  // ==========================================================
  // Array writes: no reset, contents are nonvolatile
  // Plain always so the array may also be preloaded from outside, as a
  // programmed part would arrive
  always @(posedge CLK_SYS)
  begin
    if (s.sweep_on)
      mem[s.sweep_idx] <= FPEC_ERASED; // RQ11 RQ3
    else if (prog_wr)
      mem[idx] <= mem[idx] & WDATA; // RQ3
  end

  assign RDATA      = s.rdata;
  assign PUMP_ON    = s.ctl.high_voltage_enable; // RQ5
  assign SWEEP_BUSY = s.sweep_on;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  property p_interlock;
    !(s.ctl.erase && s.ctl.program_select);
  endproperty
  a_interlock: assert property (p_interlock) // RQ9
    else $error("erase and program both set");

  property p_hv_seq;
    $rose(PUMP_ON) |-> $past(s.armed && s.prot_read
                             && (s.ctl.erase || s.ctl.program_select));
  endproperty
  a_hv_seq: assert property (p_hv_seq) // RQ4
    else $error("high voltage without proper sequence");

  property p_pump_off;
    WR && is_ctrl && !WDATA[3] |=> !PUMP_ON;
  endproperty
  a_pump_off: assert property (p_pump_off) // RQ5
    else $error("pump still on after clear");

  property p_mass_block;
    $rose(PUMP_ON) && s.ctl.erase && s.ctl.whole_array_select
      |-> $past(bpr) == FPEC_BPR_OPEN;
  endproperty
  a_mass_block: assert property (p_mass_block) // RQ14
    else $error("mass erase with protection");

  property p_prot;
    $rose(PUMP_ON) |-> !$past(target_prot);
  endproperty
  a_prot: assert property (p_prot) // RQ20
    else $error("high voltage on protected target");

  property p_page_only;
    s.sweep_on && !s.ctl.whole_array_select
      |-> s.sweep_idx[13:6] == s.lat_addr[13:6];
  endproperty
  a_page_only: assert property (p_page_only) // RQ10
    else $error("page sweep left its page");

  property p_swept;
    s.sweep_on ##1 1'b1 |-> mem[$past(s.sweep_idx)] == FPEC_ERASED;
  endproperty
  a_swept: assert property (p_swept) // RQ3
    else $error("swept byte not erased");

  property p_row;
    WR && in_arr && PUMP_ON && s.ctl.program_select && !row_hit
      && !s.sweep_on |=> mem[$past(idx)] == $past(mem[idx]);
  endproperty
  a_row: assert property (p_row) // RQ2
    else $error("write outside latched row");

  property p_ctrl_read;
    RD && is_ctrl |=> RDATA == {FPEC_CTRL_PAD, $past(s.ctl)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) // RQ8
    else $error("control read mismatch");

  property p_latch;
    s.armed && !$fell(s.armed) ##1 s.armed
      |-> $stable(s.lat_addr);
  endproperty
  a_latch: assert property (p_latch) // RQ19
    else $error("latched target moved");

  property p_sweep_stop;
    !PUMP_ON |=> !SWEEP_BUSY;
  endproperty
  a_sweep_stop: assert property (p_sweep_stop) // RQ5
    else $error("erase sweep without high voltage");

  property p_erase_cfg;
    $rose(s.sweep_on)
      |-> $past(s.ctl.erase && s.ctl.high_voltage_enable);
  endproperty
  a_erase_cfg: assert property (p_erase_cfg) // RQ7
    else $error("sweep started outside erase configuration");

  property p_mass_start;
    $rose(s.sweep_on) && $past(s.ctl.whole_array_select)
      |-> s.sweep_idx == '0;
  endproperty
  a_mass_start: assert property (p_mass_start) // RQ6
    else $error("mass sweep not started at array base");

  property p_page_start;
    $rose(s.sweep_on) && !$past(s.ctl.whole_array_select)
      |-> s.sweep_idx[FPEC_PAGE_SH-1:0] == FPEC_PROT_LOW;
  endproperty
  a_page_start: assert property (p_page_start) // RQ10
    else $error("page sweep not started on page boundary");

  property p_page_end;
    $fell(s.sweep_on) && $past(s.ctl.erase && s.ctl.high_voltage_enable
                               && !s.ctl.whole_array_select)
      |-> $past(s.sweep_idx[FPEC_PAGE_SH-1:0]) == FPEC_PAGE_LAST;
  endproperty
  a_page_end: assert property (p_page_end) // RQ1
    else $error("page sweep ended before last byte");

  property p_prot_start;
    $rose(PUMP_ON) && $past(bpr) != FPEC_BPR_OPEN
      |-> $past(s.lat_addr[FPEC_ARR_AW-1:FPEC_PAGE_SH]) < $past(bpr);
  endproperty
  a_prot_start: assert property (p_prot_start) // RQ22
    else $error("high voltage at or above protect start");

  property p_arr_read;
    RD && in_arr |=> RDATA == $past(mem[idx]);
  endproperty
  a_arr_read: assert property (p_arr_read) // RQ3
    else $error("array read data mismatch");

  property p_prog_bits;
    prog_wr && !s.sweep_on
      |=> (mem[$past(idx)] & ~$past(mem[idx])) == '0;
  endproperty
  a_prog_bits: assert property (p_prog_bits) // RQ3
    else $error("programming turned a bit from zero to one");

  c_page: cover property ($rose(s.sweep_on)
                          && !s.ctl.whole_array_select);
  c_mass: cover property ($rose(s.sweep_on)
                          && s.ctl.whole_array_select);
  c_prog: cover property (prog_wr);
  c_refuse: cover property (WR && is_ctrl && WDATA[3] && !hv_ok
                            && !PUMP_ON);

endmodule // fpec_top

// ==== fpec_top_tb.sv ====
// Self-checking testbench for the flash program and erase sequencer
`timescale 1ns/1ps
module fpec_top_tb
  import fpec_pkg::*;
;
  // ==========================================================
  // Signals
  logic        CLK_SYS = 1'b0;
  logic        RESET_N = 1'b0;
  logic [15:0] ADDR    = 16'h0000;
  logic [7:0]  WDATA   = 8'h00;
  logic        WR      = 1'b0;
  logic        RD      = 1'b0;
  logic [7:0]  RDATA;
  logic        PUMP_ON;
  logic        SWEEP_BUSY;
  int          err_total = 0;
  int          compares  = 0;

  fpec_top dut (
    .CLK_SYS    (CLK_SYS),
    .RESET_N    (RESET_N),
    .ADDR       (ADDR),
    .WDATA      (WDATA),
    .WR         (WR),
    .RD         (RD),
    .RDATA      (RDATA),
    .PUMP_ON    (PUMP_ON),
    .SWEEP_BUSY (SWEEP_BUSY)
  );

  always #12.5 CLK_SYS = ~CLK_SYS;

  // Array is nonvolatile and unknown at start; begin from erased
  initial
  begin
    for (int i = 0; i < FPEC_ARR_BYTES; i++)
      dut.mem[i] = FPEC_ERASED;
  end

  // ==========================================================
  // Bus and checking tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge CLK_SYS);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'b1;
    @(posedge CLK_SYS);
    WR    <= 1'b0;
    #1;
  endtask

  task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
    @(posedge CLK_SYS);
    ADDR <= a;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    RD   <= 1'b0;
    #1;
    chk(RDATA, exp);
  endtask

  // Select, read protect byte, latch target, then ask for high voltage
  task automatic arm(input logic [7:0] sel, input logic [15:0] a);
    wr(FPEC_CTRL_ADDR, sel);
    @(posedge CLK_SYS);
    ADDR <= FPEC_PROT_ADDR;
    RD   <= 1'b1;
    @(posedge CLK_SYS);
    RD   <= 1'b0;
    wr(a, FPEC_ERASED);
    wr(FPEC_CTRL_ADDR, sel | 8'h08);
  endtask

  task automatic done_op;
    wr(FPEC_CTRL_ADDR, 8'h08);
    wr(FPEC_CTRL_ADDR, 8'h00);
  endtask

  task automatic prog(input logic [15:0] a, input logic [7:0] d);
    arm(8'h01, a);
    chk(PUMP_ON, 1'b1);
    wr(a, d);
    wr(a + 16'h0020, 8'h00);
    done_op();
  endtask

  // Counts sweep cycles; the wait for its start is bounded
  task automatic sweep(input int n);
    int k;
    k = 0;
    while (SWEEP_BUSY !== 1'b1 && k < 8)
    begin
      @(posedge CLK_SYS);
      #1;
      k++;
    end
    k = 0;
    while (SWEEP_BUSY === 1'b1 && k < 20000)
    begin
      @(posedge CLK_SYS);
      #1;
      k++;
    end
    chk(k, n);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdc(FPEC_CTRL_ADDR, 8'h00);
    wr(FPEC_CTRL_ADDR, 8'h03);
    rdc(FPEC_CTRL_ADDR, 8'h00);
    wr(FPEC_CTRL_ADDR, 8'h08);
    rdc(FPEC_CTRL_ADDR, 8'h00);
    chk(PUMP_ON, 1'b0);
    wr(FPEC_CTRL_ADDR, 8'h04);
    rdc(FPEC_CTRL_ADDR, 8'h04);
    wr(FPEC_CTRL_ADDR, 8'h01);
    wr(FPEC_CTRL_ADDR, 8'h03);
    rdc(FPEC_CTRL_ADDR, 8'h01);
    wr(FPEC_CTRL_ADDR, 8'h00);
    wr(FPEC_CTRL_ADDR, 8'h02);
    wr(16'hC000, 8'h00);
    wr(FPEC_CTRL_ADDR, 8'h0A);
    rdc(FPEC_CTRL_ADDR, 8'h02);
    wr(FPEC_CTRL_ADDR, 8'h00);
    rdc(16'hFE07, FPEC_RD_NONE);
    $display("test regs done");
  endtask

  task automatic t_page;
    prog(16'hC020, 8'h5A);
    prog(16'hC040, 8'h12);
    rdc(16'hC020, 8'h5A);
    rdc(16'hC060, FPEC_ERASED);
    arm(8'h02, 16'hC010);
    sweep(64);
    done_op();
    rdc(16'hC020, FPEC_ERASED);
    rdc(16'hC040, 8'h12);
    prog(FPEC_TRIM_ADDR, 8'h55);
    arm(8'h02, 16'hFFF0);
    sweep(64);
    done_op();
    rdc(FPEC_TRIM_ADDR, FPEC_ERASED);
    $display("test page done");
  endtask

  task automatic t_mass;
    prog(FPEC_TRIM_ADDR, 8'h33);
    arm(8'h06, FPEC_PROT_ADDR);
    sweep(16384);
    rdc(FPEC_CTRL_ADDR, 8'h0E);
    done_op();
    rdc(16'hC040, FPEC_ERASED);
    rdc(FPEC_TRIM_ADDR, FPEC_ERASED);
    $display("test mass done");
  endtask

  task automatic t_prot;
    prog(FPEC_PROT_ADDR, 8'hFE);
    arm(8'h06, 16'hC000);
    rdc(FPEC_CTRL_ADDR, 8'h06);
    chk(PUMP_ON, 1'b0);
    wr(FPEC_CTRL_ADDR, 8'h00);
    arm(8'h02, 16'hFF80);
    rdc(FPEC_CTRL_ADDR, 8'h02);
    wr(FPEC_CTRL_ADDR, 8'h00);
    arm(8'h02, 16'hFF7F);
    sweep(64);
    rdc(FPEC_CTRL_ADDR, 8'h0A);
    done_op();
    $display("test protect done");
  endtask

  // ==========================================================
  // Run control
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    #(25 * 40000);
    err_total++;
    close_out();
  end

  initial
  begin
    repeat (8) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    t_regs();
    t_page();
    t_mass();
    t_prot();
    close_out();
  end

endmodule // fpec_top_tb
